// ### core/counter_pkg.sv
// What this block does
// - Add frequency increment into phase accumulator whenever the mode says accumulate.
// - Mode field is five bits with its lowest bit at position 26.
// - Mode selects one of 32 modes: accumulate condition and both pin outputs.
// - Six-bit primary pin field; top bit clear is port A, set is reserved.
// - Six-bit secondary pin field, same encoding, top-bit-set values reserved.
// - Writing zero disables the counter: no accumulation, no pin drive.
// - A control write changes the operating mode at once.
// - Tap divider picks oscillator divided by 128 down to 1.
// - Synthesizer modes accumulate always; accumulator bit 31 is the reference.
// - Synth modes drive none, primary, or primary plus inverse on secondary.
// - NCO modes always accumulate and drive bit 31, differential adds inverse.
// - Positive level detect accumulates on delayed primary high; feedback inverts.
// - Rising edge detect accumulates on one-delay high and two-delay low.
// - Negative level detect accumulates on delayed primary low; feedback inverts.
// - Falling edge detect accumulates on one-delay low and two-delay high.
// - Logic modes drive nothing; low mode bits enable four input terms.
// - Primary input delayed one and two clocks, secondary input one clock.
// - Counter drive reaches a pin only when its direction bit is output.
package counter_pkg;
    localparam int CTR_COUNT = 2;
    localparam int DATA_W = 32;
    localparam int PIN_COUNT = 32;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] FREQ_RESET = 32'h0000_0000;
    localparam logic [31:0] PHASE_RESET = 32'h0000_0000;
    localparam int MODE_LSB = 26;
    localparam int MODE_W = 5;
    localparam int DIV_LSB = 23;
    localparam int DIV_W = 3;
    localparam int SECONDARY_PIN_SELECT_LSB = 9;
    localparam int PRIMARY_PIN_SELECT_LSB = 0;
    localparam int PIN_W = 6;
    localparam int PIN_PORT_BIT = 5;
    localparam int PHASE_MSB = 31;
    localparam int VCO_MULT = 16;
    localparam int DIV_MAX = 128;
    localparam int DIV_LOG2 = $clog2(DIV_MAX);
    localparam logic [2:0] DIV_BY_ONE = 3'h7;
    localparam logic [4:0] MODE_OFF = 5'h00;
    localparam logic [4:0] MODE_SYN_INT = 5'h01;
    localparam logic [4:0] MODE_SYN_SE = 5'h02;
    localparam logic [4:0] MODE_SYN_DIFF = 5'h03;
    localparam logic [4:0] MODE_NCO_SE = 5'h04;
    localparam logic [4:0] MODE_NCO_DIFF = 5'h05;
    localparam logic [4:0] MODE_DUTY_SE = 5'h06;
    localparam logic [4:0] MODE_DUTY_DIFF = 5'h07;
    localparam logic [4:0] MODE_POS = 5'h08;
    localparam logic [4:0] MODE_POS_FB = 5'h09;
    localparam logic [4:0] MODE_RISE = 5'h0A;
    localparam logic [4:0] MODE_RISE_FB = 5'h0B;
    localparam logic [4:0] MODE_NEG = 5'h0C;
    localparam logic [4:0] MODE_NEG_FB = 5'h0D;
    localparam logic [4:0] MODE_FALL = 5'h0E;
    localparam logic [4:0] MODE_FALL_FB = 5'h0F;
    localparam int LOGIC_BIT = 4;
endpackage : counter_pkg

// ### core/synth_tap.sv
`timescale 1ns/1ns
`default_nettype none
// Digital side of one synthesizer: counts oscillator edges and picks a tap.
module synth_tap #(
    parameter int DIV_LOG2 = counter_pkg::DIV_LOG2
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic vco_i,
    input wire logic [counter_pkg::DIV_W-1:0] tap_i,
    output logic synth_o
);
    localparam int DIV_W_LOCAL = counter_pkg::DIV_W;
    logic vco_prev_reg;
    logic [DIV_LOG2-1:0] div_reg;
    logic [DIV_W_LOCAL-1:0] tap_idx;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            vco_prev_reg <= 1'b0;
            div_reg <= '0;
        end else if (ce_i) begin
            vco_prev_reg <= vco_i;
            if (vco_i && !vco_prev_reg) begin
                div_reg <= div_reg + 1'b1;
            end
        end
    end

    // Tap 0 takes the top divider bit (divide by 128); each step halves.
    assign tap_idx = DIV_W_LOCAL'(DIV_LOG2 - 1) - tap_i;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            synth_o <= 1'b0;
        end else if (ce_i) begin
            if (tap_i == counter_pkg::DIV_BY_ONE) begin
                synth_o <= vco_i;
            end else begin
                synth_o <= div_reg[tap_idx];
            end
        end
    end
endmodule : synth_tap
`default_nettype wire

// ### core/dual_counter.sv
`timescale 1ns/1ns
`default_nettype none
module dual_counter #(
    parameter int CTR_COUNT = counter_pkg::CTR_COUNT,
    parameter int PIN_COUNT = counter_pkg::PIN_COUNT
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [CTR_COUNT-1:0] ctrl_we_i,
    input wire logic [CTR_COUNT-1:0] freq_we_i,
    input wire logic [CTR_COUNT-1:0] phase_we_i,
    input wire logic [31:0] wdata_i,
    input wire logic [PIN_COUNT-1:0] pin_dir_i,
    input wire logic [PIN_COUNT-1:0] pin_i,
    input wire logic [CTR_COUNT-1:0] vco_i,
    output logic [CTR_COUNT-1:0][31:0] ctrl_o,
    output logic [CTR_COUNT-1:0][31:0] freq_o,
    output logic [CTR_COUNT-1:0][31:0] phase_o,
    output logic [CTR_COUNT-1:0] synth_ref_o,
    output logic [CTR_COUNT-1:0] synth_out_o,
    output logic [PIN_COUNT-1:0] pin_o,
    output logic [PIN_COUNT-1:0] pin_oe_o
);
    logic [CTR_COUNT-1:0] a1_reg;
    logic [CTR_COUNT-1:0] a2_reg;
    logic [CTR_COUNT-1:0] b1_reg;
    logic [CTR_COUNT-1:0] carry_reg;
    logic [CTR_COUNT-1:0] prim_drv;
    logic [CTR_COUNT-1:0] sec_drv;
    logic [CTR_COUNT-1:0] acc_en;
    logic [CTR_COUNT-1:0][counter_pkg::PIN_W-1:0] primary_pin_select;
    logic [CTR_COUNT-1:0][counter_pkg::PIN_W-1:0] secondary_pin_select;

    genvar c;
    genvar p;
    generate
        for (c = 0; c < CTR_COUNT; c++) begin : g_ctr
            logic [counter_pkg::MODE_W-1:0] mode;
            logic [counter_pkg::DIV_W-1:0] tap;
            logic a_raw;
            logic b_raw;
            logic [32:0] sum;

            // Write takes effect on the very next cycle's behaviour.
            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    ctrl_o[c] <= counter_pkg::CTRL_RESET;
                end else if (ce_i && ctrl_we_i[c]) begin
                    ctrl_o[c] <= wdata_i;
                end
            end

            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    freq_o[c] <= counter_pkg::FREQ_RESET;
                end else if (ce_i && freq_we_i[c]) begin
                    freq_o[c] <= wdata_i;
                end
            end

            assign mode = ctrl_o[c][counter_pkg::MODE_LSB +:
                counter_pkg::MODE_W];
            assign tap = ctrl_o[c][counter_pkg::DIV_LSB +:
                counter_pkg::DIV_W];
            assign primary_pin_select[c] = ctrl_o[c][counter_pkg::PRIMARY_PIN_SELECT_LSB +:
                counter_pkg::PIN_W];
            assign secondary_pin_select[c] = ctrl_o[c][counter_pkg::SECONDARY_PIN_SELECT_LSB +:
                counter_pkg::PIN_W];

            // Reserved second-port selections read as low.
            assign a_raw = primary_pin_select[c][counter_pkg::PIN_PORT_BIT] ? 1'b0 :
                pin_i[primary_pin_select[c][counter_pkg::PIN_PORT_BIT-1:0]];
            assign b_raw = secondary_pin_select[c][counter_pkg::PIN_PORT_BIT] ? 1'b0 :
                pin_i[secondary_pin_select[c][counter_pkg::PIN_PORT_BIT-1:0]];

            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    a1_reg[c] <= 1'b0;
                    a2_reg[c] <= 1'b0;
                    b1_reg[c] <= 1'b0;
                end else if (ce_i) begin
                    a1_reg[c] <= a_raw;
                    a2_reg[c] <= a1_reg[c];
                    b1_reg[c] <= b_raw;
                end
            end

            always_comb begin
                acc_en[c] = 1'b0;
                prim_drv[c] = 1'b0;
                sec_drv[c] = 1'b0;
                if (mode[counter_pkg::LOGIC_BIT]) begin
                    acc_en[c] = (mode[0] & !a1_reg[c] & !b1_reg[c])
                        | (mode[1] & a1_reg[c] & !b1_reg[c])
                        | (mode[2] & !a1_reg[c] & b1_reg[c])
                        | (mode[3] & a1_reg[c] & b1_reg[c]);
                end else begin
                    case (mode)
                        counter_pkg::MODE_OFF: begin
                            acc_en[c] = 1'b0;
                        end
                        counter_pkg::MODE_SYN_INT: begin
                            acc_en[c] = 1'b1;
                        end
                        counter_pkg::MODE_SYN_SE: begin
                            acc_en[c] = 1'b1;
                            prim_drv[c] = synth_out_o[c];
                        end
                        counter_pkg::MODE_SYN_DIFF: begin
                            acc_en[c] = 1'b1;
                            prim_drv[c] = synth_out_o[c];
                            sec_drv[c] = !synth_out_o[c];
                        end
                        counter_pkg::MODE_NCO_SE: begin
                            acc_en[c] = 1'b1;
                            prim_drv[c] = phase_o[c][31];
                        end
                        counter_pkg::MODE_NCO_DIFF: begin
                            acc_en[c] = 1'b1;
                            prim_drv[c] = phase_o[c][31];
                            sec_drv[c] = !phase_o[c][31];
                        end
                        counter_pkg::MODE_DUTY_SE: begin
                            acc_en[c] = 1'b1;
                            prim_drv[c] = carry_reg[c];
                        end
                        counter_pkg::MODE_DUTY_DIFF: begin
                            acc_en[c] = 1'b1;
                            prim_drv[c] = carry_reg[c];
                            sec_drv[c] = !carry_reg[c];
                        end
                        counter_pkg::MODE_POS: begin
                            acc_en[c] = a1_reg[c];
                        end
                        counter_pkg::MODE_POS_FB: begin
                            acc_en[c] = a1_reg[c];
                            sec_drv[c] = !a1_reg[c];
                        end
                        counter_pkg::MODE_RISE: begin
                            acc_en[c] = a1_reg[c] & !a2_reg[c];
                        end
                        counter_pkg::MODE_RISE_FB: begin
                            acc_en[c] = a1_reg[c] & !a2_reg[c];
                            sec_drv[c] = !a1_reg[c];
                        end
                        counter_pkg::MODE_NEG: begin
                            acc_en[c] = !a1_reg[c];
                        end
                        counter_pkg::MODE_NEG_FB: begin
                            acc_en[c] = !a1_reg[c];
                            sec_drv[c] = !a1_reg[c];
                        end
                        counter_pkg::MODE_FALL: begin
                            acc_en[c] = !a1_reg[c] & a2_reg[c];
                        end
                        counter_pkg::MODE_FALL_FB: begin
                            acc_en[c] = !a1_reg[c] & a2_reg[c];
                            sec_drv[c] = !a1_reg[c];
                        end
                        default: begin
                            acc_en[c] = 1'b0;
                        end
                    endcase
                end
            end

            assign sum = {1'b0, phase_o[c]} + {1'b0, freq_o[c]};

            // A core write to the accumulator wins over accumulation.
            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    phase_o[c] <= counter_pkg::PHASE_RESET;
                    carry_reg[c] <= 1'b0;
                end else if (ce_i) begin
                    if (phase_we_i[c]) begin
                        phase_o[c] <= wdata_i;
                        carry_reg[c] <= 1'b0;
                    end else if (acc_en[c]) begin
                        phase_o[c] <= sum[31:0];
                        carry_reg[c] <= sum[32];
                    end else begin
                        carry_reg[c] <= 1'b0;
                    end
                end
            end

            // Reference for the external oscillator, multiplied by 16 there.
            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    synth_ref_o[c] <= 1'b0;
                end else if (ce_i) begin
                    synth_ref_o[c] <= (mode == counter_pkg::MODE_SYN_INT
                        || mode == counter_pkg::MODE_SYN_SE
                        || mode == counter_pkg::MODE_SYN_DIFF)
                        && phase_o[c][counter_pkg::PHASE_MSB];
                end
            end

            synth_tap u_synth (
                .sys_clk_i(sys_clk_i),
                .rstn_i(rstn_i),
                .ce_i(ce_i),
                .vco_i(vco_i[c]),
                .tap_i(tap),
                .synth_o(synth_out_o[c])
            );
        end

        for (p = 0; p < PIN_COUNT; p++) begin : g_pin
            logic drv;

            always_comb begin
                drv = 1'b0;
                for (int k = 0; k < CTR_COUNT; k++) begin
                    if (!primary_pin_select[k][counter_pkg::PIN_PORT_BIT]
                        && primary_pin_select[k][counter_pkg::PIN_PORT_BIT-1:0]
                        == (counter_pkg::PIN_PORT_BIT)'(p)) begin
                        drv = drv | prim_drv[k];
                    end
                    if (!secondary_pin_select[k][counter_pkg::PIN_PORT_BIT]
                        && secondary_pin_select[k][counter_pkg::PIN_PORT_BIT-1:0]
                        == (counter_pkg::PIN_PORT_BIT)'(p)) begin
                        drv = drv | sec_drv[k];
                    end
                end
            end

            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    pin_o[p] <= 1'b0;
                    pin_oe_o[p] <= 1'b0;
                end else if (ce_i) begin
                    pin_o[p] <= drv & pin_dir_i[p];
                    pin_oe_o[p] <= pin_dir_i[p];
                end
            end
        end
    endgenerate
endmodule : dual_counter
`default_nettype wire

// ### tb/dual_counter_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module dual_counter_monitor #(
    parameter int CTR_COUNT = 2,
    parameter int PIN_COUNT = 32
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic [CTR_COUNT-1:0] ctrl_we_i,
    input wire logic [CTR_COUNT-1:0] phase_we_i,
    input wire logic [31:0] wdata_i,
    input wire logic [PIN_COUNT-1:0] pin_dir_i,
    input wire logic [PIN_COUNT-1:0] pin_i,
    input wire logic [CTR_COUNT-1:0][31:0] ctrl_o,
    input wire logic [CTR_COUNT-1:0][31:0] freq_o,
    input wire logic [CTR_COUNT-1:0][31:0] phase_o,
    input wire logic [PIN_COUNT-1:0] pin_o,
    input wire logic [PIN_COUNT-1:0] pin_oe_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    logic [31:0] c;
    logic a_now, b_now, a1, a2, b1, st, go;
    logic [1:0] settled;
    assign c = ctrl_o[0];
    assign a_now = !c[5] && pin_i[c[4:0]];
    assign b_now = !c[14] && pin_i[c[13:9]];
    assign st = settled == 2'd3 && ce_i && ctrl_o[1][30:26] == 5'h00;
    assign go = settled == 2'd3 && ce_i && !phase_we_i[0];
    function automatic logic acc_on(logic [4:0] m, logic x1, logic x2,
                                    logic y1);
        if (m[4]) return m[{y1, x1}];
        if (m[3]) return (m[2] ? !x1 : x1) && (!m[1] || (m[2] ? x2 : !x2));
        return m != 5'h00;
    endfunction : acc_on
    // Own copy of the input delay chain, valid once the mode has settled.
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            a1 <= 1'b0;
            a2 <= 1'b0;
            b1 <= 1'b0;
        end else if (ce_i) begin
            a1 <= a_now;
            a2 <= a1;
            b1 <= b_now;
        end
    end
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i)
            settled <= 2'd0;
        else if (!ce_i || ctrl_we_i[0])
            settled <= 2'd0;
        else if (settled != 2'd3)
            settled <= settled + 2'd1;
    end
    property p_ctrl_write;
        ce_i && ctrl_we_i[0] |=> ctrl_o[0] == $past(wdata_i);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control write not applied");
    property p_phase_write;
        ce_i && phase_we_i[0] |=> phase_o[0] == $past(wdata_i);
    endproperty
    a_phase_write: assert property (p_phase_write)
        else $error("accumulator write not applied");
    property p_acc;
        go |=> phase_o[0] == $past(phase_o[0]) + ($past(acc_on(c[30:26],
            a1, a2, b1)) ? $past(freq_o[0]) : 32'h0000_0000);
    endproperty
    a_acc: assert property (p_acc)
        else $error("accumulation wrong for mode");
    property p_off;
        c[30:26] == 5'h00 && ce_i && !phase_we_i[0] |=> $stable(phase_o[0]);
    endproperty
    a_off: assert property (p_off)
        else $error("disabled counter accumulated");
    property p_dir;
        (pin_o & ~pin_oe_o) == '0;
    endproperty
    a_dir: assert property (p_dir)
        else $error("pin driven while input");
    property p_nco_pin;
        st && c[30:26] == 5'h05 && !c[5] && !c[14] && pin_dir_i[c[4:0]]
            && pin_dir_i[c[13:9]] |=> pin_o[$past(c[4:0])] ==
            $past(phase_o[0][31]) && pin_o[$past(c[13:9])] !=
            $past(phase_o[0][31]);
    endproperty
    a_nco_pin: assert property (p_nco_pin)
        else $error("differential oscillator pins wrong");
    property p_fb;
        st && c[30:29] == 2'b01 && c[26] && !c[14] && pin_dir_i[c[13:9]]
            |=> pin_o[$past(c[13:9])] == !$past(a1);
    endproperty
    a_fb: assert property (p_fb)
        else $error("feedback pin wrong");
    property p_quiet;
        (ctrl_o[0][30] || ctrl_o[0][30:26] == 5'h00) && (ctrl_o[1][30] ||
            ctrl_o[1][30:26] == 5'h00) && ce_i |=> pin_o == '0;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("pin driven in quiet mode");
    c_rise: cover property (go && c[30:26] == 5'h0A && a1 && !a2);
    c_nco: cover property (st && c[30:26] == 5'h05);
    c_logic: cover property (go && c[30] && acc_on(c[30:26], a1, a2, b1));
endmodule : dual_counter_monitor
bind dual_counter dual_counter_monitor #(.CTR_COUNT(CTR_COUNT),
    .PIN_COUNT(PIN_COUNT)) u_mon (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .ce_i(ce_i), .ctrl_we_i(ctrl_we_i), .phase_we_i(phase_we_i),
    .wdata_i(wdata_i), .pin_dir_i(pin_dir_i), .pin_i(pin_i),
    .ctrl_o(ctrl_o), .freq_o(freq_o), .phase_o(phase_o), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o));
`default_nettype wire

// ### tb/pin_far_side.sv
`timescale 1ns/1ns
`default_nettype none
module pin_far_side (
    input wire logic sys_clk_i,
    input wire logic [31:0] pin_o,
    input wire logic [31:0] pin_oe_o,
    input wire logic [31:0] ext_i,
    output logic [31:0] pin_i,
    output logic [1:0] vco_o
);
    assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_i);
    initial vco_o = 2'b00;
    // Stand-in for the analog oscillators: free-running square waves.
    always @(posedge sys_clk_i) #1 vco_o <= ~vco_o;
endmodule : pin_far_side
`default_nettype wire

// ### tb/dual_counter_tb.sv
`timescale 1ns/1ns
`default_nettype none
module dual_counter_tb;
    logic sys_clk_i, rstn_i, ce_i;
    logic [1:0] ctrl_we, freq_we, phase_we, vco, synth_ref, synth_out;
    logic [31:0] wdata, pin_dir, pin_in, ext, pin_o, pin_oe;
    logic [1:0][31:0] ctrl, freq, phase;
    int errors, checked;
    dual_counter u_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(ce_i),
        .ctrl_we_i(ctrl_we), .freq_we_i(freq_we), .phase_we_i(phase_we),
        .wdata_i(wdata), .pin_dir_i(pin_dir), .pin_i(pin_in), .vco_i(vco),
        .ctrl_o(ctrl), .freq_o(freq), .phase_o(phase),
        .synth_ref_o(synth_ref),
        .synth_out_o(synth_out), .pin_o(pin_o), .pin_oe_o(pin_oe));
    pin_far_side u_far (.sys_clk_i(sys_clk_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe), .ext_i(ext), .pin_i(pin_in), .vco_o(vco));
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : step
    task automatic cmp(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    // Kind 0 is control, 1 frequency increment, 2 phase accumulator.
    task automatic wr(input int k, input int kind, input logic [31:0] d);
        wdata = d;
        ctrl_we = (kind == 0) ? 2'(1 << k) : 2'b00;
        freq_we = (kind == 1) ? 2'(1 << k) : 2'b00;
        phase_we = (kind == 2) ? 2'(1 << k) : 2'b00;
        step(1);
        ctrl_we = 2'b00;
        freq_we = 2'b00;
        phase_we = 2'b00;
        step(1);
    endtask : wr
    function automatic logic cond(input logic [4:0] m, input logic a,
                                  input logic b);
        if (m[4]) return m[{b, a}];
        if (m[3]) return !m[1] && (a != m[2]);
        return m != 5'h00;
    endfunction : cond
    task automatic t_reset;
        cmp("ctrl", 32'h0000_0000, ctrl[0]);
        cmp("phase", 32'h0000_0000, phase[0]);
        cmp("pins", 32'h0000_0000, pin_o);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_nco;
        logic b;
        pin_dir = 32'h0000_000C;
        wr(0, 2, 32'h0000_0000);
        wr(0, 1, 32'h9000_0001);
        wr(0, 0, 32'h1400_0602);
        cmp("ctrl", 32'h1400_0602, ctrl[0]);
        cmp("freq", 32'h9000_0001, freq[0]);
        // The pins show the accumulator top bit one cycle later.
        repeat (4) begin
            b = phase[0][31];
            step(1);
            cmp("nco pins", {30'h0, !b, b},
                {30'h0, pin_o[3:2]});
        end
        ce_i = 1'b0;
        step(2);
        ce_i = 1'b1;
        pin_dir = 32'h0000_0004;
        step(2);
        cmp("input pin", 32'h0000_0000, {31'h0, pin_o[3]});
        cmp("pin enable", 32'h0000_0004, pin_oe);
        wr(0, 0, 32'h0000_0602);
        cmp("phase", 32'h8000_0008, phase[0]);
        step(3);
        cmp("phase", 32'h8000_0008, phase[0]);
        cmp("pins", 32'h0000_0000, pin_o);
        $display("t_nco done");
    endtask : t_nco
    task automatic t_synth;
        logic p;
        logic s;
        int toggles;
        toggles = 0;
        pin_dir = 32'h0000_000C;
        wr(0, 2, 32'h0000_0000);
        // Top bit near 6 MHz keeps the oscillator in its range.
        wr(0, 1, 32'h0C49_BA5E);
        wr(0, 0, 32'h0F80_0602);
        repeat (64) begin
            p = phase[0][31];
            s = synth_out[0];
            step(1);
            cmp("synth ref", {31'h0, p}, {31'h0, synth_ref[0]});
            cmp("synth pins", {30'h0, !s, s},
                {30'h0, pin_o[3:2]});
        end
        // The model oscillator rises every second cycle: 4 toggles in 512.
        wr(0, 0, 32'h0C00_0602);
        s = synth_out[0];
        repeat (512) begin
            step(1);
            if (synth_out[0] !== s) toggles++;
            s = synth_out[0];
        end
        cmp("synth toggles", 32'h0000_0004, 32'(toggles));
        wr(0, 0, 32'h0000_0200);
        $display("t_synth done");
    endtask : t_synth
    task automatic t_modes;
        pin_dir = 32'h0000_0000;
        for (int k = 0; k < 2; k++) begin
            for (int ab = 0; ab < 4; ab++) begin
                ext = 32'(ab);
                for (int m = 0; m < 32; m++) begin
                    wr(k, 0, 32'h0000_0200);
                    wr(k, 1, 32'h0000_0001);
                    wr(k, 2, 32'h0000_0000);
                    wr(k, 0, 32'h0000_0200 | 32'(m << 26));
                    step(3);
                    wr(k, 0, 32'h0000_0200);
                    cmp("mode count", cond(5'(m), ab[0], ab[1]) ?
                        32'h0000_0005 : 32'h0000_0000, phase[k]);
                end
            end
        end
        $display("t_modes done");
    endtask : t_modes
    task automatic t_edge(input logic [4:0] m, input logic idle);
        ext = {31'h0, idle};
        pin_dir = 32'h0000_0002;
        wr(0, 1, 32'h0000_0001);
        wr(0, 2, 32'h0000_0000);
        wr(0, 0, 32'h0000_0200 | {1'b0, m, 26'h0});
        repeat (3) begin
            ext[0] = !idle;
            step(1);
            ext[0] = idle;
            step(2);
        end
        step(2);
        wr(0, 0, 32'h0000_0200);
        cmp("edge count", 32'h0000_0003, phase[0]);
        $display("t_edge done");
    endtask : t_edge
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        #400000;
        errors++;
        report_and_stop;
    end
    initial begin
        rstn_i = 1'b0;
        ce_i = 1'b1;
        ctrl_we = 2'b00;
        freq_we = 2'b00;
        phase_we = 2'b00;
        wdata = 32'h0000_0000;
        pin_dir = 32'h0000_0000;
        ext = 32'h0000_0000;
        errors = 0;
        checked = 0;
        step(8);
        rstn_i = 1'b1;
        step(1);
        t_reset;
        t_nco;
        t_synth;
        t_modes;
        t_edge(counter_pkg::MODE_RISE, 1'b0);
        t_edge(counter_pkg::MODE_FALL_FB, 1'b1);
        report_and_stop;
    end
endmodule : dual_counter_tb
`default_nettype wire
